// *** verilog/line_sync_pkg.sv ***
/*
 * constants and encodings shared by the line sync and ordering barrier unit.
 * assumes a single core clock domain and a synchronous active-high reset.
 */
// Notes on behaviour
// [RULE_01] strongly ordered system: barrier is a plain no-op
// [RULE_02] barrier waits until older accesses globally visible
// [RULE_03] barrier leaves mixed access type outcomes unchanged
// [RULE_04] address is base plus sign-extended 16-bit offset
// [RULE_05] act on one line in every needed cache
// [RULE_06] only load-type refill or invalid translation faults
// [RULE_07] writeback errors cache error, bus errors bus error
// [RULE_08] kernel region address error is a build option
// [RULE_09] data watch on line sync is a build option
// [RULE_10] locked lines stay untouched by line sync
// [RULE_11] also act on shared outer cache levels
// [RULE_12] coherent instruction caches: line sync is no-op
// [RULE_13] broadcast only for coherent cacheability attribute
// [RULE_14] all affected levels broadcast alike or none
// [RULE_15] release 6 makes broadcast mandatory
// [RULE_16] release 1 raises reserved instruction exception
// [RULE_17] line sync needs no privilege, any mode
// [RULE_18] software issues one sync per written line
// [RULE_19] software follows with barrier and hazard jump
// [RULE_20] software avoids syncing lines executing meanwhile
// [RULE_21] barrier type 0x14 waits for earlier line syncs
package line_sync_pkg;

    localparam int unsigned OFFSET_W     = 16;
    localparam int unsigned STYPE_W      = 5;
    localparam int unsigned LEVEL_W      = 3;
    localparam int unsigned EXC_W        = 3;

    // barrier subtype that also waits for global invalidates and line syncs
    localparam logic [STYPE_W-1:0] STYPE_GINV = 5'h14;

    // every cache level, private and shared, that may hold instructions
    localparam logic [LEVEL_W-1:0] ALL_LEVELS = 3'h7;

    localparam logic RST_READY = 1'b0;
    localparam logic RST_PULSE = 1'b0;

    typedef enum logic [EXC_W-1:0] {
        EXC_NONE        = 3'b000,
        EXC_TLB_REFILL  = 3'b001,
        EXC_TLB_INVALID = 3'b010,
        EXC_ADDR_ERR    = 3'b011,
        EXC_CACHE_ERR   = 3'b100,
        EXC_BUS_ERR     = 3'b101,
        EXC_RESERVED    = 3'b110,
        EXC_WATCH       = 3'b111
    } exc_code_e;

endpackage

// *** verilog/sync_pending_counter.sv ***
/*
 * counter of broadcast line syncs that other processors have not yet finished.
 * assumes the retire pulse never arrives while the count is zero.
 */
`timescale 1ns/10ps
module sync_pending_counter #(
    parameter int unsigned CNT_W = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             issuePulse,
    input  wire logic             retirePulse,
    output logic                  idle,
    output logic [CNT_W-1:0]      pending
);

    initial begin
        if (CNT_W < 1 || CNT_W > 16) begin
            $error("sync_pending_counter: CNT_W out of range");
        end
    end

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             idle_reg;
    wire  logic       atMax;
    wire  logic       doInc;
    wire  logic       doDec;

    assign atMax = (count_reg == {CNT_W{1'b1}});
    assign doInc = issuePulse & ~retirePulse & ~atMax;
    assign doDec = retirePulse & ~issuePulse & (count_reg != '0);

    always_comb begin
        count_next = count_reg;
        if (doInc) begin
            count_next = count_reg + CNT_W'(1);
        end else if (doDec) begin
            count_next = count_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= '0;
            idle_reg  <= 1'b1;
        end else begin
            count_reg <= count_next;
            idle_reg  <= (count_next == '0);
        end
    end

    assign idle    = idle_reg;
    assign pending = count_reg;

    count_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (issuePulse && !retirePulse && !atMax) |=> (count_reg == $past(count_reg) + CNT_W'(1)))
        else $error("pending count did not step up");

    idle_match_a: assert property (@(posedge sys_clk) disable iff (rst)
        idle_reg == (count_reg == '0))
        else $error("idle flag disagrees with count");

endmodule

// *** verilog/line_sync_unit.sv ***
/*
 * executes the ordering barrier and the cache line sync instruction:
 * address formation, translation, per-line cache sync, broadcast, faults.
 * assumes the pipeline holds an issued op until issueReady, that the
 * translation and cache sides answer each request with one ack pulse, and
 * that remote processors report each finished broadcast with bcastDone.
 */
`timescale 1ns/10ps
module line_sync_unit #(
    parameter int unsigned ADDR_W          = 32,
    parameter int unsigned RELEASE         = 6,
    parameter bit          STRONG_ORDER    = 1'b0,
    parameter bit          HW_ICOHERENT    = 1'b0,
    parameter bit          GLOBALIZE       = 1'b1,
    parameter bit          GLOBAL_INVAL    = 1'b1,
    parameter bit          KERNEL_ADDR_ERR = 1'b1,
    parameter bit          WATCH_ON_SYNC   = 1'b0,
    parameter int unsigned PEND_W          = 4
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst,
    // pipeline side
    input  wire logic                                 issueValid,
    input  wire logic                                 issueIsBarrier,
    input  wire logic [line_sync_pkg::STYPE_W-1:0]    issueStype,
    input  wire logic [ADDR_W-1:0]                    issueBase,
    input  wire logic [line_sync_pkg::OFFSET_W-1:0]   issueOffset,
    output logic                                      issueReady,
    output logic                                      doneValid,
    output logic                                      excValid,
    output line_sync_pkg::exc_code_e                  excCode,
    // translation side
    output logic                                      xlatReq,
    output logic [ADDR_W-1:0]                         xlatVaddr,
    output logic                                      xlatLoadType,
    input  wire logic                                 xlatAck,
    input  wire logic                                 xlatRefill,
    input  wire logic                                 xlatInvalid,
    input  wire logic                                 xlatKernelFault,
    input  wire logic                                 xlatCoherent,
    input  wire logic                                 watchMatch,
    // cache hierarchy side
    output logic                                      cacheReq,
    output logic [ADDR_W-1:0]                         cacheAddr,
    output logic [line_sync_pkg::LEVEL_W-1:0]         cacheLevels,
    output logic                                      cacheGlobal,
    output logic                                      cacheKeepLocked,
    input  wire logic                                 cacheAck,
    input  wire logic                                 cacheWbErr,
    input  wire logic                                 cacheBusErr,
    input  wire logic                                 bcastDone,
    // memory ordering side
    input  wire logic                                 storesDrained,
    output logic                                      barrierHold
);

    initial begin
        if (ADDR_W <= line_sync_pkg::OFFSET_W || ADDR_W > 64) begin
            $error("line_sync_unit: ADDR_W must exceed the offset width");
        end
        if (RELEASE < 1 || RELEASE > 6) begin
            $error("line_sync_unit: RELEASE must be 1 to 6");
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_XLAT    = 3'b001,
        S_CACHE   = 3'b010,
        S_BARRIER = 3'b011,
        S_RESP    = 3'b100
    } state_e;

    state_e                     state_reg;
    state_e                     state_next;
    logic [ADDR_W-1:0]          addr_reg;
    logic [line_sync_pkg::STYPE_W-1:0] stype_reg;
    logic                       global_reg;
    line_sync_pkg::exc_code_e   exc_reg;
    line_sync_pkg::exc_code_e   exc_next;
    logic                       ready_reg;
    logic                       done_reg;
    logic                       excFlag_reg;
    logic                       xlatReq_reg;
    logic                       cacheReq_reg;
    logic                       hold_reg;

    wire logic                  accept;
    wire logic [ADDR_W-1:0]     effAddr;
    wire logic                  relOne;
    wire logic                  mustGlobal;
    wire logic                  wantGlobal;
    wire logic                  xlatFault;
    wire line_sync_pkg::exc_code_e xlatExc;
    wire logic                  cacheFault;
    wire line_sync_pkg::exc_code_e cacheExc;
    wire logic                  waitSyncs;
    wire logic                  barrierMet;
    wire logic                  pendIdle;
    wire logic                  bcastIssue;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    assign accept     = (state_reg == S_IDLE) & ready_reg & issueValid;
    // no privilege input: the op is taken in any mode
    assign effAddr    = issueBase                                               // RULE_04
                      + {{(ADDR_W-line_sync_pkg::OFFSET_W){issueOffset[line_sync_pkg::OFFSET_W-1]}},
                         issueOffset};
    assign relOne     = (RELEASE == 1);                                         // RULE_16
    assign mustGlobal = (RELEASE >= 6);                                         // RULE_15
    // one flag for every level, so levels never differ in broadcast mode
    assign wantGlobal = xlatCoherent & (GLOBALIZE | mustGlobal);                // RULE_13 RULE_14

    // only load-type faults can come back; store, modify and inhibit never do
    assign xlatFault  = xlatRefill | xlatInvalid                                // RULE_06
                      | (xlatKernelFault & KERNEL_ADDR_ERR)                     // RULE_08
                      | (watchMatch & WATCH_ON_SYNC);                           // RULE_09
    assign xlatExc    = xlatRefill  ? line_sync_pkg::EXC_TLB_REFILL :
                        xlatInvalid ? line_sync_pkg::EXC_TLB_INVALID :
                        (xlatKernelFault & KERNEL_ADDR_ERR) ? line_sync_pkg::EXC_ADDR_ERR :
                        line_sync_pkg::EXC_WATCH;

    assign cacheFault = cacheWbErr | cacheBusErr;                               // RULE_07
    assign cacheExc   = cacheWbErr ? line_sync_pkg::EXC_CACHE_ERR :
                                     line_sync_pkg::EXC_BUS_ERR;

    assign waitSyncs  = GLOBAL_INVAL & (stype_reg == line_sync_pkg::STYPE_GINV); // RULE_21
    // older accesses drained; access type is never looked at here
    assign barrierMet = storesDrained & (~waitSyncs | pendIdle);                // RULE_02 RULE_03
    assign bcastIssue = (state_reg == S_CACHE) & cacheAck & ~cacheFault & global_reg;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        state_next = state_reg;
        exc_next   = exc_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (accept) begin
                    exc_next = line_sync_pkg::EXC_NONE;
                    if (issueIsBarrier) begin
                        state_next = STRONG_ORDER ? S_RESP : S_BARRIER;         // RULE_01
                    end else if (relOne) begin
                        exc_next   = line_sync_pkg::EXC_RESERVED;               // RULE_16
                        state_next = S_RESP;
                    end else if (HW_ICOHERENT) begin
                        state_next = S_RESP;                                    // RULE_12
                    end else begin
                        state_next = S_XLAT;                                    // RULE_17
                    end
                end
            end
            S_XLAT: begin
                if (xlatAck) begin
                    if (xlatFault) begin
                        exc_next   = xlatExc;
                        state_next = S_RESP;
                    end else begin
                        state_next = S_CACHE;
                    end
                end
            end
            S_CACHE: begin
                if (cacheAck) begin
                    if (cacheFault) begin
                        exc_next = cacheExc;                                    // RULE_07
                    end
                    state_next = S_RESP;
                end
            end
            S_BARRIER: begin
                if (barrierMet) begin
                    state_next = S_RESP;
                end
            end
            S_RESP: begin
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            exc_reg   <= line_sync_pkg::EXC_NONE;
            ready_reg <= line_sync_pkg::RST_READY;
            done_reg  <= line_sync_pkg::RST_PULSE;
            excFlag_reg <= line_sync_pkg::RST_PULSE;
        end else begin
            state_reg <= state_next;
            exc_reg   <= exc_next;
            ready_reg <= (state_next == S_IDLE) & ~accept;
            done_reg  <= (state_next == S_RESP);
            excFlag_reg <= (state_next == S_RESP) & (exc_next != line_sync_pkg::EXC_NONE);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_reg  <= '0;
            stype_reg <= '0;
        end else if (accept) begin
            addr_reg  <= effAddr;
            stype_reg <= issueStype;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            global_reg <= 1'b0;
        end else if (state_reg == S_XLAT && xlatAck) begin
            global_reg <= wantGlobal;                                           // RULE_13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xlatReq_reg  <= 1'b0;
            cacheReq_reg <= 1'b0;
            hold_reg     <= 1'b0;
        end else begin
            xlatReq_reg  <= (state_next == S_XLAT) & ~(state_reg == S_XLAT);
            cacheReq_reg <= (state_next == S_CACHE) & ~(state_reg == S_CACHE);
            hold_reg     <= (state_next == S_BARRIER);                          // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outstanding broadcasts

    sync_pending_counter #(
        .CNT_W (PEND_W)
    ) u_pending (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .issuePulse  (bcastIssue),
        .retirePulse (bcastDone),
        .idle        (pendIdle),
        .pending     ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign issueReady      = ready_reg;
    assign doneValid       = done_reg;
    assign excValid        = excFlag_reg;
    assign excCode         = exc_reg;
    assign xlatReq         = xlatReq_reg;
    assign xlatVaddr       = addr_reg;
    assign xlatLoadType    = 1'b1;                                              // RULE_06
    assign cacheReq        = cacheReq_reg;
    assign cacheAddr       = addr_reg;                                          // RULE_05
    assign cacheLevels     = line_sync_pkg::ALL_LEVELS;                         // RULE_11
    assign cacheGlobal     = global_reg;                                        // RULE_14
    assign cacheKeepLocked = 1'b1;                                              // RULE_10
    assign barrierHold     = hold_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    strong_nop_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
        (accept && issueIsBarrier && STRONG_ORDER) |=> (doneValid && !excValid))
        else $error("barrier on strong ordering was not a plain no-op");

    barrier_drain_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
        (state_reg == S_BARRIER && !storesDrained) |=> (state_reg == S_BARRIER))
        else $error("barrier left before older accesses drained");

    ginv_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_21
        (state_reg == S_BARRIER && waitSyncs && !pendIdle) |=> !doneValid)
        else $error("type 0x14 barrier finished with line syncs pending");

    addr_form_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
        (accept && !issueIsBarrier && !relOne && !HW_ICOHERENT)
        |=> (xlatReq && xlatVaddr == $past(effAddr)))
        else $error("translation address is not base plus offset");

    tlb_cause_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
        (state_reg == S_XLAT && xlatAck && xlatRefill)
        |=> (excValid && excCode == line_sync_pkg::EXC_TLB_REFILL))
        else $error("refill fault not reported as load refill");

    cache_err_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_07
        (state_reg == S_CACHE && cacheAck && cacheWbErr)
        |=> (excValid && excCode == line_sync_pkg::EXC_CACHE_ERR))
        else $error("writeback error not reported as cache error");

    no_bcast_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_13
        (state_reg == S_XLAT && xlatAck && !xlatFault && !xlatCoherent)
        |=> (cacheReq && !cacheGlobal))
        else $error("non-coherent line sync was broadcast");

    rel6_bcast_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_15
        (state_reg == S_XLAT && xlatAck && !xlatFault && xlatCoherent && mustGlobal)
        |=> (cacheReq && cacheGlobal))
        else $error("coherent line sync not broadcast on release 6");

    rel1_ri_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
        (accept && !issueIsBarrier && relOne)
        |=> (excValid && excCode == line_sync_pkg::EXC_RESERVED && !cacheReq))
        else $error("release 1 line sync did not raise reserved instruction");

    one_line_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
        cacheReq |-> ($past(state_reg == S_XLAT && xlatAck && !xlatFault) && $stable(addr_reg)))
        else $error("cache sync aimed at a different line");

endmodule

// *** test/line_sync_partner.sv ***
/* far side of the line sync unit: translation, cache levels and remote cores.
   assumes knob names the faults to report; flags mean something only with an ack. */
`timescale 1ns/10ps
module line_sync_partner (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       xlatReq,
    input  wire logic       cacheReq,
    input  wire logic       cacheGlobal,
    input  wire logic [6:0] knob,
    input  wire logic [1:0] lat,
    input  wire logic       holdBcast,
    output logic            xlatAck,
    output logic [4:0]      xlatFlag,
    output logic            cacheAck,
    output logic [1:0]      cacheErr,
    output logic            bcastDone
);
    int xWait;
    int cWait;
    int pend;
    // flags toggle outside ack cycles so a stale sample shows up
    always @(posedge sys_clk) begin
        xlatAck   <= 1'b0;
        cacheAck  <= 1'b0;
        bcastDone <= 1'b0;
        xlatFlag  <= ~xlatFlag;
        cacheErr  <= ~cacheErr;
        if (rst) begin
            xWait = -1;
            cWait = -1;
            pend = 0;
            xlatFlag <= 5'h0;
            cacheErr <= 2'h0;
        end else begin
            if (xlatReq) xWait = lat;
            if (cacheReq) cWait = lat;
            // remote cores finish at least one cycle after the ack
            if (!holdBcast && pend > 0) begin
                bcastDone <= 1'b1;
                pend--;
            end
            if (xWait == 0) begin
                xlatAck  <= 1'b1;
                xlatFlag <= knob[4:0];
            end
            if (cWait == 0) begin
                cacheAck <= 1'b1;
                cacheErr <= knob[6:5];
                if (cacheGlobal && knob[6:5] == 2'h0) pend++;
            end
            if (xWait >= 0) xWait--;
            if (cWait >= 0) cWait--;
        end
    end
endmodule

// *** test/tb_line_sync_unit.sv ***
/* self-checking bench: release 6 unit, plus a strongly ordered release 1 twin
   fed the same ops. assumes line_sync_partner answers both sides. */
`timescale 1ns/10ps
module tb_line_sync_unit;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        issueValid = 1'b0;
    logic        issueIsBarrier = 1'b0;
    logic [4:0]  issueStype = 5'h0;
    logic [31:0] issueBase = 32'h0;
    logic [15:0] issueOffset = 16'h0;
    logic        storesDrained = 1'b1;
    logic [6:0]  knob = 7'h0;
    logic [1:0]  lat = 2'h0;
    logic        holdBcast = 1'b0;
    logic        issueReady, doneValid, excValid, xlatReq, xlatLoadType, xlatAck;
    logic        cacheReq, cacheGlobal, cacheKeepLocked, cacheAck, bcastDone;
    logic        barrierHold, done2, exc2, curBar;
    logic [31:0] xlatVaddr, cacheAddr;
    logic [4:0]  xlatFlag;
    logic [2:0]  cacheLevels;
    logic [1:0]  cacheErr;
    line_sync_pkg::exc_code_e excCode, code2;
    int          nErrors = 0, testsRun = 0, nOps = 0, n2 = 0;
    logic [31:0] seed = 32'h8c0a_e7ae;
    logic [2:0]  expQ[$];
    logic [4:0]  stypes[7] = '{5'h0, 5'h4, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

    always #10 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////////////////////
    line_sync_unit u_line_sync_unit (
        .sys_clk(sys_clk), .rst(rst), .issueValid(issueValid),
        .issueIsBarrier(issueIsBarrier), .issueStype(issueStype), .issueBase(issueBase),
        .issueOffset(issueOffset), .issueReady(issueReady), .doneValid(doneValid),
        .excValid(excValid), .excCode(excCode), .xlatReq(xlatReq), .xlatVaddr(xlatVaddr),
        .xlatLoadType(xlatLoadType), .xlatAck(xlatAck), .xlatRefill(xlatFlag[0]),
        .xlatInvalid(xlatFlag[1]), .xlatKernelFault(xlatFlag[2]),
        .xlatCoherent(xlatFlag[3]), .watchMatch(xlatFlag[4]), .cacheReq(cacheReq),
        .cacheAddr(cacheAddr), .cacheLevels(cacheLevels), .cacheGlobal(cacheGlobal),
        .cacheKeepLocked(cacheKeepLocked), .cacheAck(cacheAck), .cacheWbErr(cacheErr[0]),
        .cacheBusErr(cacheErr[1]), .bcastDone(bcastDone), .storesDrained(storesDrained),
        .barrierHold(barrierHold));
    line_sync_unit #(.RELEASE(1), .STRONG_ORDER(1'b1)) u_line_sync_unit_r1 (
        .sys_clk(sys_clk), .rst(rst), .issueValid(issueValid),
        .issueIsBarrier(issueIsBarrier), .issueStype(issueStype), .issueBase(issueBase),
        .issueOffset(issueOffset), .issueReady(), .doneValid(done2), .excValid(exc2),
        .excCode(code2), .xlatReq(), .xlatVaddr(), .xlatLoadType(), .xlatAck(xlatAck),
        .xlatRefill(xlatFlag[0]), .xlatInvalid(xlatFlag[1]),
        .xlatKernelFault(xlatFlag[2]), .xlatCoherent(xlatFlag[3]),
        .watchMatch(xlatFlag[4]), .cacheReq(), .cacheAddr(), .cacheLevels(),
        .cacheGlobal(), .cacheKeepLocked(), .cacheAck(cacheAck), .cacheWbErr(cacheErr[0]),
        .cacheBusErr(cacheErr[1]), .bcastDone(bcastDone), .storesDrained(storesDrained),
        .barrierHold());
    line_sync_partner u_line_sync_partner (
        .sys_clk(sys_clk), .rst(rst), .xlatReq(xlatReq), .cacheReq(cacheReq),
        .cacheGlobal(cacheGlobal), .knob(knob), .lat(lat), .holdBcast(holdBcast),
        .xlatAck(xlatAck), .xlatFlag(xlatFlag), .cacheAck(cacheAck),
        .cacheErr(cacheErr), .bcastDone(bcastDone));
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic endOfTest;
        $display("checks %0d errors %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one op: hd = edge at which stores drain, hb = edge remote cores resume
    task automatic runOp(input logic bar, input logic [4:0] st, input int hd,
                         input int hb, input logic [6:0] kb);
        logic [31:0] b, ea;
        logic [15:0] o;
        logic [2:0]  ex;
        logic        xf;
        int          m, nx, nc, doneAt;
        b = $random(seed);
        o = $random(seed);
        ea = b + {{16{o[15]}}, o};
        xf = kb[0] | kb[1] | kb[2];
        nx = 0;
        nc = 0;
        doneAt = 0;
        // watch match (kb[4]) never raises a fault in this build
        ex = bar ? line_sync_pkg::EXC_NONE
           : kb[0] ? line_sync_pkg::EXC_TLB_REFILL
           : kb[1] ? line_sync_pkg::EXC_TLB_INVALID
           : kb[2] ? line_sync_pkg::EXC_ADDR_ERR
           : kb[5] ? line_sync_pkg::EXC_CACHE_ERR
           : kb[6] ? line_sync_pkg::EXC_BUS_ERR : line_sync_pkg::EXC_NONE;
        expQ.push_back(ex);
        nOps++;
        curBar = bar;
        knob <= kb;
        lat <= $random(seed);
        issueIsBarrier <= bar;
        issueStype <= st;
        issueBase <= b;
        issueOffset <= o;
        storesDrained <= (hd == 0);
        issueValid <= 1'b1;
        m = 0;
        do begin
            @(posedge sys_clk);
            m++;
        end while (issueReady !== 1'b1 && m < 200);
        issueValid <= 1'b0;
        for (m = 1; m < 300 && doneAt == 0; m++) begin
            @(posedge sys_clk);
            if (m == hd) storesDrained <= 1'b1;
            if (m == hb) holdBcast <= 1'b0;
            if (bar && m == hd) check(barrierHold, 1'b1);
            if (xlatReq === 1'b1) begin
                nx++;
                check(xlatVaddr, ea);
                check(xlatLoadType, 1'b1);
            end
            if (cacheReq === 1'b1) begin
                nc++;
                check(cacheAddr, ea);
                check(cacheLevels, line_sync_pkg::ALL_LEVELS);
                check(cacheKeepLocked, 1'b1);
                check(cacheGlobal, kb[3]);
            end
            if (doneValid === 1'b1) begin
                doneAt = m;
                ex = expQ.pop_front();
                check(excCode, ex);
                check(excValid, ex != 3'h0);
            end
        end
        check(doneAt > hd && doneAt > hb, 1'b1);
        check(nx, bar ? 0 : 1);
        check(nc, (bar | xf) ? 0 : 1);
    endtask
////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (done2 === 1'b1) begin
            n2++;
            check(code2, curBar ? 3'h0 : line_sync_pkg::EXC_RESERVED);
            check(exc2, !curBar);
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (stypes[i]) runOp(1'b1, stypes[i], 3, 0, 7'h00);
        repeat (40) runOp(1'b0, 5'h0, 0, 0, $random(seed));
        holdBcast <= 1'b1;
        runOp(1'b0, 5'h0, 0, 0, 7'h08);
        runOp(1'b1, line_sync_pkg::STYPE_GINV, 0, 6, 7'h00);
        check(n2, nOps);
        endOfTest();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        nErrors++;
        endOfTest();
    end
endmodule
